//--- rtl/pps_pkg.sv
// Purpose: shared constants and state type for the port pin sharing block
// Assumes: direction bit 1 means input, 0 means output
// Notes:   sharing masks give which pins OR or AND their alternate output
package pps_pkg;

  // ****************************************
  // port widths
  // ****************************************
  localparam int unsigned P0_W = 5;
  localparam int unsigned P1_W = 7;
  localparam int unsigned P6_W = 6;
  localparam int unsigned P8_W = 8;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic       RST_TOG  = 1'b0;

  // ****************************************
  // sharing masks per port (bit positions)
  // ****************************************
  localparam logic [7:0] P1_OR_M  = 8'h02;
  localparam logic [7:0] P1_AND_M = 8'h54;
  localparam logic [7:0] P2_OR_M  = 8'hDE;
  localparam logic [7:0] P3_OR_M  = 8'h0B;
  localparam logic [7:0] P8_OR_M  = 8'h02;
  localparam logic [7:0] P8_AND_M = 8'h54;
  localparam logic [7:0] NO_M     = 8'h00;

  // ****************************************
  // whole state of the block
  // ****************************************
  typedef struct packed {
    logic [7:0] s1_0, s2_0, o0, oe0, pu0, rd0;
    logic [7:0] s1_1, s2_1, o1, oe1, pu1, rd1;
    logic [7:0] s1_2, s2_2, o2, oe2, pu2, rd2;
    logic [7:0] s1_3, s2_3, o3, oe3, pu3, rd3;
    logic [7:0] s1_4, s2_4, o4, oe4, rd4;
    logic [7:0] s1_5, s2_5, o5, oe5, rd5;
    logic [7:0] s1_6, s2_6, o6, oe6, rd6;
    logic [7:0] s1_7, s2_7, rd7;
    logic [7:0] s1_8, s2_8, o8, oe8, pu8, rd8;
    logic       pclk_tog;
  } pps_state_t;

endpackage

//--- rtl/pps_port_pins.sv
// Purpose: pin level sharing of ports 0 to 8 with on-chip peripherals
// Assumes: one clock, synchronous active-low reset, pins sampled twice
// Notes:   all pin outputs, enables and read data come from flip-flops
`timescale 1ns/100ps

// What this block does
// R01: port 0 is five bits, each bit's direction set by its direction bit.
// R02: port 0 bit 0 feeds the NMI request, bits 1-4 external irqs.
// R03: port 0 pins serve port and interrupt inputs together, no select.
// R04: ports 0,1,2,3,8 enable a pin pull-up when its pull-up bit is set.
// R05: port 1 is seven bits with direction, shared with serial and irqs.
// R06: port 1 bits 0,3,5 give port and alternate input together.
// R07: port 1 bit 1 drives latch OR serial data out.
// R08: port 1 bits 2,4,6 drive latch AND alternate output.
// R09: port 2 is eight bits with direction, bits 0-7 shared with timers.
// R10: port 2 bits 0 and 5 give port and capture input together.
// R11: port 2 bits 1-4,6,7 drive latch OR timer output.
// R12: port 3 is eight bits; bit 0 clock out, bits 1-4 timer C.
// R13: port 3 bits 2,4 give port and alternate input together.
// R14: port 3 bits 0,1,3 drive latch OR clock or timer output.
// R15: processor clock output shows half the system clock when enabled.
// R16: ports 4-6 select port or LCD output per control mode bit.
// R17: port 6 is six bits with direction, LCD segments 12-17 in control.
// R18: port 7 is an eight bit input port shared with analog inputs.
// R19: port 7 digital read and analog input work together.
// R20: port 8 bits 0,3,5 give port and alternate input together.
// R21: port 8 bit 1 drives latch OR serial channel 1 data out.
// R22: port 8 bits 2,4,6 drive latch AND serial clock or CAN transmit.
// R23: software keeps the latch at one for alternate-only AND pins.
// R24: software keeps the latch at zero for alternate-only OR pins.
// R25: selector pins pick port or alternate by a software control bit.
// R26: input direction turns the driver off except ports 4-6 in control mode; pin level reads back.
module pps_port_pins
  import pps_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic [4:0]        port0_direction_reg,
  input  wire logic [4:0]        port0_pullup_reg,
  input  wire logic [4:0]        port0_out_latch,
  input  wire logic [4:0]        port0_pin_i,
  output logic      [4:0]        port0_pin_o,
  output logic      [4:0]        port0_pin_oe,
  output logic      [4:0]        port0_pullup_en,
  output logic      [4:0]        port0_read_data,
  input  wire logic [6:0]        port1_direction_reg,
  input  wire logic [6:0]        port1_pullup_reg,
  input  wire logic [6:0]        port1_out_latch,
  input  wire logic [6:0]        port1_pin_i,
  output logic      [6:0]        port1_pin_o,
  output logic      [6:0]        port1_pin_oe,
  output logic      [6:0]        port1_pullup_en,
  output logic      [6:0]        port1_read_data,
  input  wire logic [7:0]        port2_direction_reg,
  input  wire logic [7:0]        port2_pullup_reg,
  input  wire logic [7:0]        port2_out_latch,
  input  wire logic [7:0]        port2_pin_i,
  output logic      [7:0]        port2_pin_o,
  output logic      [7:0]        port2_pin_oe,
  output logic      [7:0]        port2_pullup_en,
  output logic      [7:0]        port2_read_data,
  input  wire logic [7:0]        port3_direction_reg,
  input  wire logic [7:0]        port3_pullup_reg,
  input  wire logic [7:0]        port3_out_latch,
  input  wire logic [7:0]        port3_pin_i,
  output logic      [7:0]        port3_pin_o,
  output logic      [7:0]        port3_pin_oe,
  output logic      [7:0]        port3_pullup_en,
  output logic      [7:0]        port3_read_data,
  input  wire logic [7:0]        port4_direction_reg,
  input  wire logic [7:0]        port4_control_mode_reg,
  input  wire logic [7:0]        port4_out_latch,
  input  wire logic [7:0]        port4_pin_i,
  output logic      [7:0]        port4_pin_o,
  output logic      [7:0]        port4_pin_oe,
  output logic      [7:0]        port4_read_data,
  input  wire logic [7:0]        port5_direction_reg,
  input  wire logic [7:0]        port5_control_mode_reg,
  input  wire logic [7:0]        port5_out_latch,
  input  wire logic [7:0]        port5_pin_i,
  output logic      [7:0]        port5_pin_o,
  output logic      [7:0]        port5_pin_oe,
  output logic      [7:0]        port5_read_data,
  input  wire logic [5:0]        port6_direction_reg,
  input  wire logic [5:0]        port6_control_mode_reg,
  input  wire logic [5:0]        port6_out_latch,
  input  wire logic [5:0]        port6_pin_i,
  output logic      [5:0]        port6_pin_o,
  output logic      [5:0]        port6_pin_oe,
  output logic      [5:0]        port6_read_data,
  input  wire logic [7:0]        port7_pin_i,
  output logic      [7:0]        port7_read_data,
  input  wire logic [7:0]        port8_direction_reg,
  input  wire logic [7:0]        port8_pullup_reg,
  input  wire logic [7:0]        port8_out_latch,
  input  wire logic [7:0]        port8_pin_i,
  output logic      [7:0]        port8_pin_o,
  output logic      [7:0]        port8_pin_oe,
  output logic      [7:0]        port8_pullup_en,
  output logic      [7:0]        port8_read_data,
  output logic                   nmi_req,
  output logic      [5:0]        ext_irq_input,
  output logic      [1:0]        serial_data_in,
  output logic      [1:0]        serial_clock_in,
  output logic      [1:0]        async_serial_rx,
  output logic      [3:0]        timer_g_capture_input,
  output logic      [1:0]        timer5_count_input,
  output logic      [3:0]        timer_c_capture_input,
  output logic      [1:0]        can_receive,
  input  wire logic [1:0]        serial_data_out,
  input  wire logic [1:0]        serial_clock_out,
  input  wire logic [1:0]        uart_transmit_out,
  input  wire logic [3:0]        timer_g_output,
  input  wire logic [1:0]        timer5_output,
  input  wire logic [1:0]        timer_c_output,
  input  wire logic              processor_clock_enable,
  input  wire logic [1:0]        can_transmit,
  input  wire logic [3:0]        lcd_common_out,
  input  wire logic [17:0]       lcd_segment_out
);
  import pps_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // OR and AND sharing; a bit in neither mask drives the plain latch
  function automatic logic [7:0] pps_mix(input logic [7:0] lat,
                                         input logic [7:0] alt,
                                         input logic [7:0] or_m,
                                         input logic [7:0] and_m);
    pps_mix = (lat & ~or_m & ~and_m) | ((lat | alt) & or_m)
            | (lat & alt & and_m);
  endfunction

  // selector: control mode bit picks the alternate output
  function automatic logic [7:0] pps_sel(input logic [7:0] pmc,
                                         input logic [7:0] lat,
                                         input logic [7:0] alt);
    pps_sel = (pmc & alt) | (~pmc & lat);
  endfunction

  // read back: pin level when input, latch when output
  function automatic logic [7:0] pps_rd(input logic [7:0] dir,
                                        input logic [7:0] pin,
                                        input logic [7:0] lat);
    pps_rd = (dir & pin) | (~dir & lat);
  endfunction

  pps_state_t st_r;
  pps_state_t st_nxt;
  logic [7:0] alt1;
  logic [7:0] alt2;
  logic [7:0] alt3;
  logic [7:0] alt8;

  // ****************************************
  // alternate output gathering
  // ****************************************
  // clock output is a toggle so the pin stays a registered output;
  // the pin therefore runs at half the system clock
  assign alt1 = {1'b0, uart_transmit_out[1], 1'b0, uart_transmit_out[0],
                 1'b0, serial_clock_out[0], serial_data_out[0], 1'b0};
  assign alt2 = {timer5_output, 1'b0, timer_g_output, 1'b0};
  assign alt3 = {4'h0, timer_c_output[1], 1'b0, timer_c_output[0],
                 st_r.pclk_tog};
  assign alt8 = {1'b0, can_transmit[1], 1'b0, can_transmit[0], 1'b0,
                 serial_clock_out[1], serial_data_out[1], 1'b0};

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    // two-stage pin synchronisers
    st_nxt.s1_0 = {3'h0, port0_pin_i};
    st_nxt.s2_0 = st_r.s1_0;
    st_nxt.s1_1 = {1'b0, port1_pin_i};
    st_nxt.s2_1 = st_r.s1_1;
    st_nxt.s1_2 = port2_pin_i;
    st_nxt.s2_2 = st_r.s1_2;
    st_nxt.s1_3 = port3_pin_i;
    st_nxt.s2_3 = st_r.s1_3;
    st_nxt.s1_4 = port4_pin_i;
    st_nxt.s2_4 = st_r.s1_4;
    st_nxt.s1_5 = port5_pin_i;
    st_nxt.s2_5 = st_r.s1_5;
    st_nxt.s1_6 = {2'h0, port6_pin_i};
    st_nxt.s2_6 = st_r.s1_6;
    st_nxt.s1_7 = port7_pin_i;
    st_nxt.s2_7 = st_r.s1_7;
    st_nxt.s1_8 = port8_pin_i;
    st_nxt.s2_8 = st_r.s1_8;
    // port 0: plain latch, interrupts only listen
    st_nxt.o0  = {3'h0, port0_out_latch}; // R03
    st_nxt.oe0 = {3'h0, ~port0_direction_reg}; // R01 R26
    st_nxt.pu0 = {3'h0, port0_pullup_reg}; // R04
    st_nxt.rd0 = pps_rd({3'h0, port0_direction_reg}, st_r.s2_0,
                        {3'h0, port0_out_latch}); // R26
    // port 1: serial and uart sharing
    st_nxt.o1  = pps_mix({1'b0, port1_out_latch}, alt1, P1_OR_M,
                         P1_AND_M); // R07 R08 R06
    st_nxt.oe1 = {1'b0, ~port1_direction_reg}; // R05 R26
    st_nxt.pu1 = {1'b0, port1_pullup_reg}; // R04
    st_nxt.rd1 = pps_rd({1'b0, port1_direction_reg}, st_r.s2_1,
                        {1'b0, port1_out_latch});
    // port 2: timer sharing
    st_nxt.o2  = pps_mix(port2_out_latch, alt2, P2_OR_M, NO_M); // R11 R10
    st_nxt.oe2 = ~port2_direction_reg; // R09 R26
    st_nxt.pu2 = port2_pullup_reg; // R04
    st_nxt.rd2 = pps_rd(port2_direction_reg, st_r.s2_2, port2_out_latch);
    // port 3: clock output and timer C
    st_nxt.pclk_tog = processor_clock_enable & ~st_r.pclk_tog; // R15
    st_nxt.o3  = pps_mix(port3_out_latch, alt3, P3_OR_M, NO_M); // R14 R13
    st_nxt.oe3 = ~port3_direction_reg; // R12 R26
    st_nxt.pu3 = port3_pullup_reg; // R04
    st_nxt.rd3 = pps_rd(port3_direction_reg, st_r.s2_3, port3_out_latch);
    // ports 4 to 6: LCD selector, control mode always drives
    st_nxt.o4  = pps_sel(port4_control_mode_reg, port4_out_latch,
                         {lcd_segment_out[3:0], lcd_common_out}); // R16 R25
    st_nxt.oe4 = port4_control_mode_reg | ~port4_direction_reg; // R16
    st_nxt.rd4 = pps_rd(port4_direction_reg, st_r.s2_4, port4_out_latch);
    st_nxt.o5  = pps_sel(port5_control_mode_reg, port5_out_latch,
                         lcd_segment_out[11:4]); // R16 R25
    st_nxt.oe5 = port5_control_mode_reg | ~port5_direction_reg; // R16
    st_nxt.rd5 = pps_rd(port5_direction_reg, st_r.s2_5, port5_out_latch);
    st_nxt.o6  = pps_sel({2'h0, port6_control_mode_reg},
                         {2'h0, port6_out_latch},
                         {2'h0, lcd_segment_out[17:12]}); // R17 R25
    st_nxt.oe6 = {2'h0, port6_control_mode_reg | ~port6_direction_reg};
    st_nxt.rd6 = pps_rd({2'h0, port6_direction_reg}, st_r.s2_6,
                        {2'h0, port6_out_latch}); // R17
    // port 7: input only, analog path untouched
    st_nxt.rd7 = st_r.s2_7; // R18 R19
    // port 8: serial channel 1 and CAN
    st_nxt.o8  = pps_mix(port8_out_latch, alt8, P8_OR_M,
                         P8_AND_M); // R21 R22 R20
    st_nxt.oe8 = ~port8_direction_reg; // R26
    st_nxt.pu8 = port8_pullup_reg; // R04
    st_nxt.rd8 = pps_rd(port8_direction_reg, st_r.s2_8, port8_out_latch);
  end

  // ****************************************
  // state register
  // ****************************************
  // reset leaves every driver off, as all pins float in reset
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st_r          <= '0;
      st_r.pclk_tog <= RST_TOG;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign port0_pin_o     = st_r.o0[4:0];
  assign port0_pin_oe    = st_r.oe0[4:0];
  assign port0_pullup_en = st_r.pu0[4:0];
  assign port0_read_data = st_r.rd0[4:0];
  assign port1_pin_o     = st_r.o1[6:0];
  assign port1_pin_oe    = st_r.oe1[6:0];
  assign port1_pullup_en = st_r.pu1[6:0];
  assign port1_read_data = st_r.rd1[6:0];
  assign port2_pin_o     = st_r.o2;
  assign port2_pin_oe    = st_r.oe2;
  assign port2_pullup_en = st_r.pu2;
  assign port2_read_data = st_r.rd2;
  assign port3_pin_o     = st_r.o3;
  assign port3_pin_oe    = st_r.oe3;
  assign port3_pullup_en = st_r.pu3;
  assign port3_read_data = st_r.rd3;
  assign port4_pin_o     = st_r.o4;
  assign port4_pin_oe    = st_r.oe4;
  assign port4_read_data = st_r.rd4;
  assign port5_pin_o     = st_r.o5;
  assign port5_pin_oe    = st_r.oe5;
  assign port5_read_data = st_r.rd5;
  assign port6_pin_o     = st_r.o6[5:0];
  assign port6_pin_oe    = st_r.oe6[5:0];
  assign port6_read_data = st_r.rd6[5:0];
  assign port7_read_data = st_r.rd7;
  assign port8_pin_o     = st_r.o8;
  assign port8_pin_oe    = st_r.oe8;
  assign port8_pullup_en = st_r.pu8;
  assign port8_read_data = st_r.rd8;

  // alternate inputs tap the second sync stage regardless of direction
  assign nmi_req               = st_r.s2_0[0]; // R02
  assign ext_irq_input         = {st_r.s2_1[5], st_r.s2_1[3],
                                  st_r.s2_0[4:1]}; // R02 R05
  assign serial_data_in        = {st_r.s2_8[0], st_r.s2_1[0]}; // R06 R20
  assign serial_clock_in       = {st_r.s2_8[2], st_r.s2_1[2]};
  assign async_serial_rx       = {st_r.s2_1[5], st_r.s2_1[3]}; // R06
  assign timer_g_capture_input = {st_r.s2_2[5], st_r.s2_2[0],
                                  2'h0}; // R10
  assign timer5_count_input    = st_r.s2_2[7:6];
  assign timer_c_capture_input = st_r.s2_3[4:1]; // R13
  assign can_receive           = {st_r.s2_8[5], st_r.s2_8[3]}; // R20

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_up2;
    reset_n ##1 reset_n ##1 reset_n;
  endsequence

  sequence s_pclk_run;
    (processor_clock_enable && !port3_out_latch[0])[*2];
  endsequence

  a_nmi_sync: assert property (s_up2 |->
    nmi_req == $past(port0_pin_i[0], 2)) // R02
    else $error("nmi request does not follow pin after two stages");
  a_p0_oe_dir: assert property (reset_n |=>
    port0_pin_oe == ~$past(port0_direction_reg)) // R01
    else $error("port 0 driver enable does not follow direction");
  a_p1_or_bit: assert property (reset_n |=> port1_pin_o[1] ==
    ($past(port1_out_latch[1]) | $past(serial_data_out[0]))) // R07
    else $error("port 1 bit 1 is not latch OR serial out");
  a_p1_and_bit: assert property (reset_n |=> port1_pin_o[4] ==
    ($past(port1_out_latch[4]) & $past(uart_transmit_out[0]))) // R08
    else $error("port 1 bit 4 is not latch AND uart out");
  a_p2_or_bits: assert property (reset_n |=> port2_pin_o[4:1] ==
    ($past(port2_out_latch[4:1]) | $past(timer_g_output))) // R11
    else $error("port 2 timer bits are not OR shared");
  a_pclk_run: assert property (s_pclk_run |=>
    port3_pin_o[0] != $past(port3_pin_o[0])) // R15
    else $error("clock output pin does not toggle when enabled");
  a_lcd_sel: assert property (reset_n && port4_control_mode_reg[0] |=>
    port4_pin_oe[0] && port4_pin_o[0] == $past(lcd_common_out[0])) // R16
    else $error("port 4 control mode does not drive common output");
  a_p7_read: assert property (s_up2 ##1 reset_n |->
    port7_read_data == $past(port7_pin_i, 3)) // R19
    else $error("port 7 read data is not pin level after three cycles");
  a_p8_or_and: assert property (reset_n |=> port8_pin_o[2:1] ==
    {$past(port8_out_latch[2]) & $past(serial_clock_out[1]),
     $past(port8_out_latch[1]) | $past(serial_data_out[1])}) // R21 R22
    else $error("port 8 serial pins are not OR/AND shared");
  a_in_no_drive: assert property (reset_n && port2_direction_reg[3] |=>
    !port2_pin_oe[3]) // R26
    else $error("input-direction pin is being driven");
  a_pullup_en: assert property (reset_n |=>
    port8_pullup_en == $past(port8_pullup_reg)) // R04
    else $error("port 8 pull-up enable does not follow its register");

endmodule // pps_port_pins

//--- sim/pps_pin_board.sv
// Purpose: board side of the shared pins, resolves every pin level
// Assumes: pins packed with port 0 in the low bits, port 8 at the top
// Notes:   an undriven pin without pull-up wanders every cycle
`timescale 1ns/100ps
module pps_pin_board
(
  input  wire logic        sys_clk,
  input  wire logic [65:0] drv_o,
  input  wire logic [65:0] drv_oe,
  input  wire logic [65:0] pull_en,
  input  wire logic [65:0] ext_val,
  input  wire logic [65:0] ext_en,
  output logic      [65:0] pin_lvl
);
  logic [65:0] wander_r = {33{2'b01}};

  // ******
  // floating lines
  // ******
  // a float must never pass for a steady level at the reader
  always @(posedge sys_clk)
  begin
    wander_r <= ~wander_r;
  end

  // device driver wins, then the board, then the pull-up
  always_comb
  begin
    pin_lvl = (drv_oe & drv_o) | (~drv_oe & ext_en & ext_val)
      | (~drv_oe & ~ext_en & (pull_en | wander_r));
  end
endmodule // pps_pin_board

//--- sim/port_pin_function_sharing_bench.sv
// Purpose: self-checking bench for the port pin sharing block
// Assumes: direction 1 is input, control mode 1 drives the lcd value
// Notes:   random inputs settle six cycles before a full comparison
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end
module port_pin_function_sharing_bench;
  import pps_pkg::*;
  logic        sys_clk, reset_n, processor_clock_enable, nmi_req;
  logic [4:0]  port0_direction_reg, port0_pullup_reg, port0_out_latch,
               port0_pin_i, port0_pin_o, port0_pin_oe, port0_pullup_en,
               port0_read_data;
  logic [6:0]  port1_direction_reg, port1_pullup_reg, port1_out_latch,
               port1_pin_i, port1_pin_o, port1_pin_oe, port1_pullup_en,
               port1_read_data;
  logic [7:0]  port2_direction_reg, port2_pullup_reg, port2_out_latch,
               port2_pin_i, port2_pin_o, port2_pin_oe, port2_pullup_en,
               port2_read_data, port3_direction_reg, port3_pullup_reg,
               port3_out_latch, port3_pin_i, port3_pin_o, port3_pin_oe,
               port3_pullup_en, port3_read_data, port8_direction_reg,
               port8_pullup_reg, port8_out_latch, port8_pin_i, port8_pin_o,
               port8_pin_oe, port8_pullup_en, port8_read_data,
               port4_direction_reg, port4_control_mode_reg, port4_out_latch,
               port4_pin_i, port4_pin_o, port4_pin_oe, port4_read_data,
               port5_direction_reg, port5_control_mode_reg, port5_out_latch,
               port5_pin_i, port5_pin_o, port5_pin_oe, port5_read_data,
               port7_pin_i, port7_read_data;
  logic [5:0]  port6_direction_reg, port6_control_mode_reg, port6_out_latch,
               port6_pin_i, port6_pin_o, port6_pin_oe, port6_read_data,
               ext_irq_input;
  logic [1:0]  serial_data_in, serial_clock_in, async_serial_rx, can_receive,
               timer5_count_input, serial_data_out, serial_clock_out,
               uart_transmit_out, timer5_output, timer_c_output, can_transmit;
  logic [3:0]  timer_g_capture_input, timer_c_capture_input, timer_g_output,
               lcd_common_out;
  logic [17:0] lcd_segment_out;
  logic [65:0] ext_val, ext_en, pin_lvl, eo, eoe, epu, pv, pk, erd, erk, nv;
  logic [31:0] seed = 32'h13a1;
  int          n_errors, samples_checked, toggles;
  logic        b;
  wire  [65:0] got_o  = {port8_pin_o, 8'h00, port6_pin_o, port5_pin_o,
    port4_pin_o, port3_pin_o, port2_pin_o, port1_pin_o, port0_pin_o};
  wire  [65:0] got_oe = {port8_pin_oe, 8'h00, port6_pin_oe, port5_pin_oe,
    port4_pin_oe, port3_pin_oe, port2_pin_oe, port1_pin_oe, port0_pin_oe};
  wire  [65:0] got_pu = {port8_pullup_en, 30'h0, port3_pullup_en,
    port2_pullup_en, port1_pullup_en, port0_pullup_en};
  wire  [65:0] got_rd = {port8_read_data, port7_read_data, port6_read_data,
    port5_read_data, port4_read_data, port3_read_data, port2_read_data,
    port1_read_data, port0_read_data};
  wire  [24:0] got_alt = {nmi_req, ext_irq_input, serial_data_in,
    serial_clock_in, async_serial_rx, timer_g_capture_input,
    timer5_count_input, timer_c_capture_input, can_receive};

  assign {port8_pin_i, port7_pin_i, port6_pin_i, port5_pin_i, port4_pin_i,
    port3_pin_i, port2_pin_i, port1_pin_i, port0_pin_i} = pin_lvl;

  pps_port_pins dut_u (.*);
  pps_pin_board board_u (.sys_clk, .drv_o(got_o), .drv_oe(got_oe),
    .pull_en(got_pu), .ext_val, .ext_en, .pin_lvl);

  // ******
  // clock, random source and reference model
  // ******
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // alternate input taps of the packed pins, z fills the unused capture bits
  function automatic logic [24:0] taps(logic [65:0] v, logic [1:0] z);
    return {v[0], v[10], v[8], v[4:1], v[58], v[5], v[60], v[7], v[10],
      v[8], v[17], v[12], z, v[19:18], v[24:21], v[63], v[61]};
  endfunction

  task automatic shuffle();
    logic [351:0] r;
    for (int i = 0; i < 11; i++)
    begin
      r[i*32 +: 32] = rnd();
    end
    {port0_direction_reg, port1_direction_reg, port2_direction_reg,
     port3_direction_reg, port4_direction_reg, port5_direction_reg,
     port6_direction_reg, port8_direction_reg, port0_pullup_reg,
     port1_pullup_reg, port2_pullup_reg, port3_pullup_reg, port8_pullup_reg,
     port4_control_mode_reg, port5_control_mode_reg, port6_control_mode_reg,
     port0_out_latch, port1_out_latch, port2_out_latch, port3_out_latch,
     port4_out_latch, port5_out_latch, port6_out_latch, port8_out_latch,
     serial_data_out, serial_clock_out, uart_transmit_out, timer_g_output,
     timer5_output, timer_c_output, processor_clock_enable, can_transmit,
     lcd_common_out, lcd_segment_out} <= r[212:0];
    ext_val <= r[278:213];
    ext_en  <= r[344:279];
  endtask

  // timeless view of every pin; port 7 acts as an input-only slot
  task automatic model();
    logic [65:0] dv, lv, cm, alt, orv, andv;
    dv = {port8_direction_reg, 8'hFF, port6_direction_reg,
      port5_direction_reg, port4_direction_reg, port3_direction_reg,
      port2_direction_reg, port1_direction_reg, port0_direction_reg};
    lv = {port8_out_latch, 8'h00, port6_out_latch, port5_out_latch,
      port4_out_latch, port3_out_latch, port2_out_latch, port1_out_latch,
      port0_out_latch};
    cm = {16'h0, port6_control_mode_reg, port5_control_mode_reg,
      port4_control_mode_reg, 28'h0};
    alt = {1'b0, can_transmit[1], 1'b0, can_transmit[0], 1'b0,
      serial_clock_out[1], serial_data_out[1], 1'b0, 8'h00, lcd_segment_out,
      lcd_common_out, 4'h0, timer_c_output[1], 1'b0, timer_c_output[0],
      1'b0, timer5_output, 1'b0, timer_g_output, 1'b0, uart_transmit_out[1],
      1'b0, uart_transmit_out[0], 1'b0, serial_clock_out[0],
      serial_data_out[0], 1'b0, 5'h0};
    orv  = {P8_OR_M, 30'h0, P3_OR_M, P2_OR_M, P1_OR_M[6:0], 5'h0};
    andv = {P8_AND_M, 46'h0, P1_AND_M[6:0], 5'h0};
    epu = {port8_pullup_reg, 30'h0, port3_pullup_reg, port2_pullup_reg,
      port1_pullup_reg, port0_pullup_reg};
    eo  = (cm & alt) | (~cm & (lv | (alt & orv)) & (~andv | alt));
    eoe = cm | ~dv;
    pv  = (eoe & eo) | (~eoe & ext_en & ext_val) | (~eoe & ~ext_en & epu);
    pk  = eoe | ext_en | epu;
    erd = (dv & pv) | (~dv & lv);
    erk = ~dv | pk;
  endtask

  task automatic settle_check();
    logic [65:0] om;
    logic [24:0] am, ae;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    model();
    // clock output phase is free running, so that bit is left out while processor_clock_enable is set
    om = ~({65'h0, processor_clock_enable} << 20);
    `CHK("pin drive", eo & om, got_o & om)
    `CHK("pin enable", eoe, got_oe)
    `CHK("pull-up", epu, got_pu)
    `CHK("read back", erd & erk, got_rd & erk)
    am = taps(pk, 2'b11);
    ae = taps(pv, 2'b00) & am;
    `CHK("alt in", ae, got_alt & am)
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ******
  // main sequence
  // ******
  initial
  begin
    reset_n = 1'b0;
    shuffle();
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("reset drive", 66'h0, got_oe | got_o)
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (40)
    begin
      @(posedge sys_clk);
      shuffle();
      settle_check();
    end
    // latency walk: nmi two edges after the pin, port 7 read after three
    @(posedge sys_clk);
    port0_direction_reg <= 5'h1F;
    ext_en <= '1;
    repeat (6) @(posedge sys_clk);
    nv = ~ext_val;
    ext_val <= nv;
    repeat (3) @(negedge sys_clk);
    `CHK("nmi", nv[0], nmi_req)
    `CHK("port7 early", ~nv[57:50], port7_read_data)
    @(negedge sys_clk);
    `CHK("port7 late", nv[57:50], port7_read_data)
    @(posedge sys_clk);
    port1_out_latch <= ~port1_out_latch;
    repeat (2) @(negedge sys_clk);
    model();
    `CHK("port1 one cycle", eo[11:5], port1_pin_o)
    // pull-ups hold every released input of ports 0-3 and 8 high
    @(posedge sys_clk);
    ext_en <= '0;
    {port0_pullup_reg, port1_pullup_reg, port2_pullup_reg, port3_pullup_reg,
     port8_pullup_reg} <= '1;
    {port0_direction_reg, port1_direction_reg, port2_direction_reg,
     port3_direction_reg, port8_direction_reg} <= '1;
    settle_check();
    // alternate outputs alone: AND pins latch high, OR pins latch low
    @(posedge sys_clk);
    {port1_direction_reg, port2_direction_reg, port3_direction_reg,
     port8_direction_reg} <= '0;
    port1_out_latch <= P1_AND_M[6:0];
    port8_out_latch <= P8_AND_M;
    {port2_out_latch, port3_out_latch} <= 16'h0000;
    settle_check();
    // processor clock output toggles every cycle while enabled
    @(posedge sys_clk);
    processor_clock_enable <= 1'b1;
    port3_out_latch <= 8'h00;
    repeat (3) @(negedge sys_clk);
    toggles = 0;
    for (int i = 0; i < 8; i++)
    begin
      b = port3_pin_o[0];
      @(negedge sys_clk);
      toggles += int'(port3_pin_o[0] !== b);
    end
    `CHK("clock out", 8, toggles)
    summarize();
  end
endmodule // port_pin_function_sharing_bench
